// ===== hdl/vtc_regs.svh
// Command codes, field positions, reset values and timing counts of the output target logic
`ifndef VTC_REGS_SVH
`define VTC_REGS_SVH

// Command codes
`define VTC_CMD_FORMAT      8'h20
`define VTC_CMD_TARGET      8'h21
`define VTC_CMD_OFFSET      8'h22

// Output format setting fields
`define VTC_FMT_REL_BIT     7
`define VTC_FMT_MODE_MSB    6
`define VTC_FMT_MODE_LSB    5
`define VTC_FMT_EXP_MSB     4
`define VTC_FMT_EXP_LSB     0
`define VTC_FMT_RESET       8'h17

// Exponent magnitudes: supported -4 .. -12, fine grid is 2^-12 V
`define VTC_EXP_MIN_K       5'h04
`define VTC_EXP_MAX_K       5'h0C
`define VTC_FINE_K          5'h0C

// DAC range per loop scale in mV, converted to fine units
`define VTC_DAC_MV_S1       700
`define VTC_DAC_MV_S2       1400
`define VTC_DAC_MV_S4       2800
`define VTC_DAC_MV_S8       6000
`define VTC_MV_TO_FINE(mv)  (((mv) * 4096) / 1000)

// Offset backup saturation, exponent -12
`define VTC_NVM_OFS_MAX     127
`define VTC_NVM_OFS_MIN     (-128)

// Slew tick
`define VTC_CLK_MHZ         20
`define VTC_SLEW_TICK_NS    1000
`define VTC_SLEW_TICK_CYC   ((`VTC_SLEW_TICK_NS * `VTC_CLK_MHZ) / 1000)

`endif

// ===== hdl/vtc_pkg.sv
// Types shared by the output target logic
package vtc_pkg;
    typedef logic [23:0]        vtc_fine_t;
    typedef logic signed [25:0] vtc_sum_t;
    typedef enum logic { VTC_POR_LOAD, VTC_RUN } vtc_phase_t;
endpackage : vtc_pkg

// ===== hdl/vtc_slew.sv
// Ramp of the reference toward its goal at a fixed step per tick
`timescale 1ns/1ps
`default_nettype none
`include "vtc_regs.svh"
module vtc_slew
    import vtc_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      sys_rst,
    // Control
    input  wire logic      load,
    input  wire vtc_fine_t loadValue,
    input  wire vtc_fine_t goal,
    input  wire logic [15:0] step,
    // Result
    output vtc_fine_t      level
);
    localparam logic [15:0] TICK_LAST = 16'(`VTC_SLEW_TICK_CYC - 1);

    logic [15:0] tickCnt;
    vtc_fine_t   diff;

    // Tick prescaler
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickCnt <= 16'h0000;
        end else if (tickCnt == TICK_LAST) begin
            tickCnt <= 16'h0000;
        end else begin
            tickCnt <= 16'(tickCnt + 16'h0001);
        end
    end

    // Distance left to travel, either direction
    always_comb begin
        diff = (goal > level) ? 24'(goal - level) : 24'(level - goal);
    end

    // A zero step would stall the ramp, so it is taken as a jump
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            level <= 24'h000000;
        end else if (load) begin
            level <= loadValue;
        end else if (tickCnt == TICK_LAST) begin
            if (step == 16'h0000 || diff <= {8'h00, step}) begin
                level <= goal;
            end else if (goal > level) begin
                level <= 24'(level + {8'h00, step});
            end else begin
                level <= 24'(level - {8'h00, step});
            end
        end
    end
endmodule : vtc_slew
`default_nettype wire

// ===== hdl/vtc_target.sv
// Output voltage target and offset commands with boot, reload and clamping
`timescale 1ns/1ps
`default_nettype none
`include "vtc_regs.svh"
module vtc_target
    import vtc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Command port from the bus front end
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [15:0] cmdWrData,
    output logic             cmdDone,
    output logic [15:0]      cmdRdData,
    output logic             cmdUnsupported,
    // Configuration bits
    input  wire logic        strapSourceSelect,
    input  wire logic        faultTargetReload,
    input  wire logic        pinIsReset,
    input  wire logic [1:0]  loopScaleFactor,
    input  wire logic [15:0] slewRateSetting,
    input  wire logic [15:0] upperVoltageLimit,
    input  wire logic [15:0] lowerVoltageLimit,
    // Default sources and events
    input  wire logic [15:0] voltageStrapValue,
    input  wire logic [15:0] nvmTargetValue,
    input  wire logic [7:0]  nvmOffsetValue,
    input  wire logic        restoreDefaults,
    input  wire logic        faultShutdown,
    input  wire logic        clearFlags,
    input  wire logic        powerGoodResetPin_n,
    // Status and results
    output logic [15:0]      bootVoltage,
    output logic [7:0]       nvmOffsetBackup,
    output logic [23:0]      referenceLevel,
    output logic             limitViolationWarning,
    output logic             invalidDataFlag,
    output logic             alertHost
);
    // DAC maxima in fine units
    localparam vtc_fine_t DAC_S1 = 24'(`VTC_MV_TO_FINE(`VTC_DAC_MV_S1));
    localparam vtc_fine_t DAC_S2 = 24'(`VTC_MV_TO_FINE(`VTC_DAC_MV_S2));
    localparam vtc_fine_t DAC_S4 = 24'(`VTC_MV_TO_FINE(`VTC_DAC_MV_S4));
    localparam vtc_fine_t DAC_S8 = 24'(`VTC_MV_TO_FINE(`VTC_DAC_MV_S8));
    localparam vtc_sum_t  OFS_MAX = 26'(`VTC_NVM_OFS_MAX);
    localparam vtc_sum_t  OFS_MIN = 26'(`VTC_NVM_OFS_MIN);

    vtc_phase_t  phase;
    logic [7:0]  formatSetting;
    vtc_fine_t   targetFine;
    vtc_fine_t   offsetFine;
    vtc_fine_t   bootFine;
    vtc_fine_t   lastStrap;
    logic        pinSync1;
    logic        pinSync2;
    logic        pinResetActive;

    logic        wrTarget;
    logic        wrOffset;
    logic        wrFormat;
    logic        fmtExpOk;
    logic [4:0]  curK;
    logic [4:0]  newK;
    logic [3:0]  curShift;
    logic [3:0]  newShift;
    vtc_fine_t   wrTargetFine;
    vtc_fine_t   wrOffsetFine;
    vtc_fine_t   dacMax;
    vtc_sum_t    candSum;
    vtc_sum_t    liveSum;
    vtc_sum_t    upperSum;
    vtc_sum_t    lowerSum;
    logic        candOverLimit;
    logic        candUnderLimit;
    logic        candOutOfDac;
    logic        offsetReject;
    logic        setWarn;
    logic        setInvalid;
    logic        slewLoad;
    vtc_fine_t   bootSource;
    vtc_fine_t   goalFine;
    vtc_fine_t   slewLevel;
    vtc_sum_t    ofsWide;

    // Write strobes, one per command
    assign wrTarget = cmdValid && cmdWrite && (cmdCode == `VTC_CMD_TARGET);
    assign wrOffset = cmdValid && cmdWrite && (cmdCode == `VTC_CMD_OFFSET);
    assign wrFormat = cmdValid && cmdWrite && (cmdCode == `VTC_CMD_FORMAT);

    // exponent magnitude from the two's complement field
    always_comb begin
        curK = 5'(~formatSetting[`VTC_FMT_EXP_MSB:`VTC_FMT_EXP_LSB] + 5'h01);
        newK = 5'(~cmdWrData[`VTC_FMT_EXP_MSB:`VTC_FMT_EXP_LSB] + 5'h01);
        curShift = 4'(`VTC_FINE_K - curK);
        newShift = 4'(`VTC_FINE_K - newK);
    end

    // only exponents -4 to -12 are accepted
    assign fmtExpOk = (newK >= `VTC_EXP_MIN_K) && (newK <= `VTC_EXP_MAX_K);

    // target mantissa taken as unsigned absolute, relative bit ignored
    // mantissa scaled onto the fine grid by the current exponent
    assign wrTargetFine = 24'({8'h00, cmdWrData} << curShift);

    assign wrOffsetFine = 24'($signed({{8{cmdWrData[15]}}, cmdWrData}) <<< curShift);

    // DAC range from the loop scale
    always_comb begin
        unique case (loopScaleFactor)
            2'h0: dacMax = DAC_S1;
            2'h1: dacMax = DAC_S2;
            2'h2: dacMax = DAC_S4;
            2'h3: dacMax = DAC_S8;
        endcase
    end

    // Limits widened to the signed sum width
    assign upperSum = $signed({10'h000, upperVoltageLimit});
    assign lowerSum = $signed({10'h000, lowerVoltageLimit});

    // candidate sum for the write under way, target plus offset
    always_comb begin
        if (wrTarget) begin
            candSum = $signed({2'h0, wrTargetFine}) + $signed({{2{offsetFine[23]}}, offsetFine});
        end else if (wrOffset) begin
            candSum = $signed({2'h0, targetFine}) + $signed({{2{wrOffsetFine[23]}}, wrOffsetFine});
        end else begin
            candSum = $signed({2'h0, targetFine}) + $signed({{2{offsetFine[23]}}, offsetFine});
        end
    end

    // Limit checks are taken before the DAC check so a limit hit warns
    assign candOverLimit  = candSum > upperSum;
    assign candUnderLimit = candSum < lowerSum;
    assign candOutOfDac   = (candSum < 26'sh0) || (candSum > $signed({2'h0, dacMax}));

    // offset outside the valid range and inside the limits is rejected
    assign offsetReject = wrOffset && candOutOfDac && !candOverLimit && !candUnderLimit;

    // target write past a limit warns
    // offset write past a limit warns
    assign setWarn = (wrTarget || (wrOffset && !offsetReject)) && (candOverLimit || candUnderLimit);

    // Invalid data: bad offset or bad exponent
    assign setInvalid = offsetReject || (wrFormat && !fmtExpOk);

    // Reset pin passes two flops before use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinSync1 <= 1'b1;
            pinSync2 <= 1'b1;
        end else begin
            pinSync1 <= powerGoodResetPin_n;
            pinSync2 <= pinSync1;
        end
    end

    // Pin counts only while configured in its reset role
    assign pinResetActive = pinIsReset && !pinSync2;

    // Boot phase: one load cycle after reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= VTC_POR_LOAD;
        end else begin
            unique case (phase)
                VTC_POR_LOAD: phase <= VTC_RUN;
                VTC_RUN:      phase <= VTC_RUN;
            endcase
        end
    end

    assign bootSource = strapSourceSelect ? {8'h00, voltageStrapValue} : {8'h00, nvmTargetValue};

    // boot value in its own storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bootFine  <= 24'h000000;
            lastStrap <= 24'h000000;
        end else if (phase == VTC_POR_LOAD || restoreDefaults) begin
            bootFine  <= bootSource;
            lastStrap <= {8'h00, voltageStrapValue};
        end
    end

    // Output format setting, mode bits read as zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            formatSetting <= `VTC_FMT_RESET;
        end else if (wrFormat && fmtExpOk) begin
            formatSetting <= {cmdWrData[`VTC_FMT_REL_BIT], 2'h0,
                              cmdWrData[`VTC_FMT_EXP_MSB:`VTC_FMT_EXP_LSB]};
        end
    end

    // Current target; boot events outrank host writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            targetFine <= 24'h000000;
        end else if (phase == VTC_POR_LOAD || restoreDefaults) begin
            targetFine <= bootSource;
        // pin reset restores the boot value
        end else if (pinResetActive) begin
            targetFine <= bootFine;
        // reload after fault from strap or memory
        end else if (faultShutdown && faultTargetReload) begin
            targetFine <= strapSourceSelect ? lastStrap : {8'h00, nvmTargetValue};
        end else if (wrTarget) begin
            targetFine <= wrTargetFine;
        end else if (wrFormat && fmtExpOk) begin
            targetFine <= (targetFine >> newShift) << newShift;
        end
        // otherwise a fault leaves the target alone
    end

    // Current offset; restored from its 8-bit backup at exponent -12
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            offsetFine <= 24'h000000;
        end else if (phase == VTC_POR_LOAD || restoreDefaults) begin
            offsetFine <= {{16{nvmOffsetValue[7]}}, nvmOffsetValue};
        end else if (wrOffset && !offsetReject) begin
            offsetFine <= wrOffsetFine;
        // signed requantise to the new exponent
        end else if (wrFormat && fmtExpOk) begin
            offsetFine <= 24'($signed($signed(offsetFine) >>> newShift) <<< newShift);
        end
    end

    // backup image saturated to the 8-bit range
    assign ofsWide = $signed({{2{offsetFine[23]}}, offsetFine});
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvmOffsetBackup <= 8'h00;
        end else if (ofsWide > OFS_MAX) begin
            nvmOffsetBackup <= 8'h7F;
        end else if (ofsWide < OFS_MIN) begin
            nvmOffsetBackup <= 8'h80;
        end else begin
            nvmOffsetBackup <= offsetFine[7:0];
        end
    end

    // Live sum of what is stored now
    assign liveSum = $signed({2'h0, targetFine}) + $signed({{2{offsetFine[23]}}, offsetFine});

    // limit clamp ahead of the DAC clamp
    // DAC ceiling clamps with no warning
    always_comb begin
        if (liveSum > upperSum) begin
            goalFine = 24'(upperSum);
        end else if (liveSum < lowerSum) begin
            goalFine = 24'(lowerSum);
        end else if (liveSum < 26'sh0) begin
            goalFine = 24'h000000;
        end else begin
            goalFine = 24'(liveSum);
        end
        if (goalFine > dacMax) begin
            goalFine = dacMax;
        end
    end

    // Jumps only on boot events; hiccup restart starts from zero anyway
    assign slewLoad = (phase == VTC_POR_LOAD) || restoreDefaults || pinResetActive;

    vtc_slew u_slew (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .load      (slewLoad),
        .loadValue (goalFine),
        .goal      (goalFine),
        .step      (slewRateSetting),
        .level     (slewLevel)
    );

    // Reference follows the ramp, registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            referenceLevel <= 24'h000000;
            bootVoltage    <= 16'h0000;
        end else begin
            referenceLevel <= slewLevel;
            bootVoltage    <= bootFine[15:0];
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            limitViolationWarning <= 1'b0;
            invalidDataFlag       <= 1'b0;
        end else begin
            limitViolationWarning <= setWarn || (limitViolationWarning && !clearFlags);
            invalidDataFlag       <= setInvalid || (invalidDataFlag && !clearFlags);
        end
    end

    // Alert stays up while any flag stands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alertHost <= 1'b0;
        end else begin
            alertHost <= setWarn || setInvalid ||
                         ((limitViolationWarning || invalidDataFlag) && !clearFlags);
        end
    end

    // readback re-expressed in the format in force now
    // one answer per command, next cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmdDone        <= 1'b0;
            cmdRdData      <= 16'h0000;
            cmdUnsupported <= 1'b0;
        end else begin
            cmdDone <= cmdValid;
            if (cmdValid) begin
                cmdUnsupported <= 1'b0;
                unique case (cmdCode)
                    `VTC_CMD_FORMAT: cmdRdData <= {8'h00, formatSetting};
                    `VTC_CMD_TARGET: cmdRdData <= 16'(targetFine >> curShift);
                    `VTC_CMD_OFFSET: cmdRdData <= 16'($signed(offsetFine) >>> curShift);
                    default: begin
                        cmdRdData      <= 16'h0000;
                        cmdUnsupported <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule : vtc_target
`default_nettype wire

// ===== hdl/placeholder_unused.sv
// Empty compilation unit kept for file ordering
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verification/vtc_target_properties.sv
// Concurrent checks on the output target logic ports
`timescale 1ns/1ps
`default_nettype none
module vtc_target_properties (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Command port
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdCode,
    input wire logic        cmdDone,
    input wire logic        cmdUnsupported,
    // Events and results
    input wire logic        restoreDefaults,
    input wire logic        clearFlags,
    input wire logic [15:0] bootVoltage,
    input wire logic [23:0] referenceLevel,
    input wire logic        limitViolationWarning,
    input wire logic        invalidDataFlag,
    input wire logic        alertHost
);
    logic [1:0] runCnt;
    // Edges since reset; the boot load cycle may move every output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            runCnt <= 2'h0;
        end else if (runCnt != 2'h3) begin
            runCnt <= runCnt + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_DONE_ONE: assert property (cmdValid |=> cmdDone) else $error("answer missing");
    AST_DONE_IDLE: assert property (!cmdValid |=> !cmdDone) else $error("answer without command");
    AST_UNSUP_SET: assert property (cmdValid && !(cmdCode inside {8'h20, 8'h21, 8'h22}) |=> cmdUnsupported)
        else $error("unknown code accepted");
    AST_KNOWN_OK: assert property (cmdValid && (cmdCode inside {8'h20, 8'h21, 8'h22}) |=> !cmdUnsupported)
        else $error("known code refused");
    AST_WARN_ALERT: assert property ($rose(limitViolationWarning) |-> ##[0:1] alertHost) else $error("no alert");
    AST_INV_ALERT: assert property ($rose(invalidDataFlag) |-> ##[0:1] alertHost) else $error("no alert");
    AST_WARN_HOLD: assert property (limitViolationWarning && !clearFlags |=> limitViolationWarning)
        else $error("warning dropped");
    AST_INV_CLEAR: assert property (clearFlags && !cmdValid && !$past(cmdValid) |=> !invalidDataFlag)
        else $error("invalid flag not cleared");
    AST_BOOT_KEEP: assert property (runCnt == 2'h3 && !restoreDefaults && !$past(restoreDefaults)
        && !$past(restoreDefaults, 2) |=> $stable(bootVoltage)) else $error("boot value moved");
    AST_REF_CEIL: assert property (referenceLevel <= 24'h006000) else $error("reference above ceiling");
    COV_UNSUP: cover property (cmdValid && cmdCode == 8'h99);
    COV_WARN: cover property ($rose(limitViolationWarning));
    COV_INV: cover property ($rose(invalidDataFlag));
endmodule : vtc_target_properties
bind vtc_target vtc_target_properties vtc_target_properties_i (.clk, .sys_rst, .cmdValid, .cmdCode, .cmdDone,
    .cmdUnsupported, .restoreDefaults, .clearFlags, .bootVoltage, .referenceLevel, .limitViolationWarning,
    .invalidDataFlag, .alertHost);
`default_nettype wire

// ===== verification/vtc_host_model.sv
// Host side model issuing command reads and writes
`timescale 1ns/1ps
`default_nettype none
module vtc_host_model (
    // Clock
    input  wire logic       clk,
    // Command port
    output var logic        cmdValid,
    output var logic        cmdWrite,
    output var logic [7:0]  cmdCode,
    output var logic [15:0] cmdWrData
);
    // Idle port at time zero
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdWrData = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] v);
        cmdValid = 1'b1;
        cmdWrite = w;
        cmdCode = c;
        cmdWrData = v;
        @(negedge clk);
        cmdValid = 1'b0;
        // Released data is inverted so a stale word cannot pass
        cmdWrData = ~v;
        @(negedge clk);
    endtask : xfer
endmodule : vtc_host_model
`default_nettype wire

// ===== verification/tb_vtc_target.sv
// Self-checking bench for the output target logic
`timescale 1ns/1ps
`default_nettype none
module tb_vtc_target;
    import vtc_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmdValid, cmdWrite, cmdDone, cmdUnsupported;
    logic [7:0]  cmdCode, nvmOffsetBackup;
    logic [15:0] cmdWrData, cmdRdData, bootVoltage, d;
    logic        strapSourceSelect = 1'b0, faultTargetReload = 1'b0, pinIsReset = 1'b1;
    logic [1:0]  loopScaleFactor = 2'h0;
    logic [15:0] slewRateSetting = 16'h0000, upperVoltageLimit = 16'h0C00, lowerVoltageLimit = 16'h0100;
    logic [15:0] voltageStrapValue = 16'h0400, nvmTargetValue = 16'h0800;
    logic [7:0]  nvmOffsetValue = 8'h08;
    logic        restoreDefaults = 1'b0, faultShutdown = 1'b0, clearFlags = 1'b0, powerGoodResetPin_n = 1'b1;
    logic        limitViolationWarning, invalidDataFlag, alertHost;
    vtc_fine_t   referenceLevel;
    // Notes: {data checked, unsupported, data}
    logic [17:0] expQ[$];
    logic [17:0] note;
    int          fail_count = 0;
    int          check_count = 0;
    int          seed = 64917;
    int          n;
    // DAC ceiling per loop scale in 2^-12 V units
    int          dacTab[4] = '{2867, 5734, 11468, 24576};

    always #25 clk = ~clk;

    vtc_target vtc_target_i (.clk, .sys_rst, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .cmdDone, .cmdRdData,
        .cmdUnsupported, .strapSourceSelect, .faultTargetReload, .pinIsReset, .loopScaleFactor, .slewRateSetting,
        .upperVoltageLimit, .lowerVoltageLimit, .voltageStrapValue, .nvmTargetValue, .nvmOffsetValue,
        .restoreDefaults, .faultShutdown, .clearFlags, .powerGoodResetPin_n, .bootVoltage, .nvmOffsetBackup,
        .referenceLevel, .limitViolationWarning, .invalidDataFlag, .alertHost);
    vtc_host_model vtc_host_model_i (.clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData);

    task automatic close_out;
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic cmp_lvl(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_lvl

    task automatic cmp_ans(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_ans

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick

    // Reads have their data checked, writes only the refusal bit
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] v, input logic [15:0] e);
        expQ.push_back({!w, !(c inside {8'h20, 8'h21, 8'h22}), e});
        vtc_host_model_i.xfer(w, c, v);
    endtask : cmd

    task automatic pulse_clear;
        clearFlags = 1'b1;
        tick(1);
        clearFlags = 1'b0;
        tick(2);
    endtask : pulse_clear

    // Bounded wait for the ramp to settle; running out ends the run
    task automatic wait_ref(input logic [23:0] e);
        for (n = 0; n < 3000 && referenceLevel !== e; n++) begin
            tick(1);
        end
        cmp_lvl(referenceLevel, e);
        if (n == 3000) begin
            close_out();
        end
    endtask : wait_ref

    // Each answer is matched against the oldest note
    always @(negedge clk) begin
        if (cmdDone === 1'b1) begin
            cmp_lvl({23'h0, expQ.size() != 0}, 24'h1);
            note = expQ.pop_front();
            cmp_ans({cmdUnsupported, note[17] ? cmdRdData : note[15:0]}, note[16:0]);
        end
    end

    initial begin
        tick(2);
        sys_rst = 1'b0;
        tick(3);
        // Boot from memory, format exponent -9
        cmp_lvl({8'h00, bootVoltage}, 24'h000800);
        cmd(0, 8'h20, 16'h0000, 16'h0017);
        cmd(0, 8'h21, 16'h0000, 16'h0100);
        cmd(0, 8'h22, 16'h0000, 16'h0001);
        wait_ref(24'h000808);
        // Relative bit set, target still absolute
        cmd(1, 8'h20, 16'h0097, 16'h0000);
        cmd(0, 8'h20, 16'h0000, 16'h0097);
        for (int i = 0; i < 4; i++) begin
            d = 16'h0020 + 16'($unsigned($random(seed)) % 96);
            cmd(1, 8'h21, d, 16'h0000);
            cmd(0, 8'h21, 16'h0000, d);
            wait_ref({5'h00, d, 3'h0} + 24'h8);
        end
        // Slow slew must not reach the goal early
        slewRateSetting = 16'h0010;
        cmd(1, 8'h21, 16'h0150, 16'h0000);
        tick(100);
        cmp_lvl({23'h0, referenceLevel === 24'h000A88}, 24'h0);
        wait_ref(24'h000A88);
        slewRateSetting = 16'h0000;
        // Target beyond either limit
        upperVoltageLimit = 16'h0A00;
        cmd(1, 8'h21, 16'h0190, 16'h0000);
        wait_ref(24'h000A00);
        cmp_lvl({22'h0, limitViolationWarning, alertHost}, 24'h3);
        cmd(1, 8'h21, 16'h0010, 16'h0000);
        wait_ref(24'h000100);
        upperVoltageLimit = 16'h0C00;
        cmd(1, 8'h21, 16'h0100, 16'h0000);
        pulse_clear();
        cmp_lvl({22'h0, limitViolationWarning, alertHost}, 24'h0);
        // Above the DAC ceiling yet under the limit clamps quietly
        cmd(1, 8'h21, 16'h0168, 16'h0000);
        wait_ref(24'h000B33);
        cmp_lvl({23'h0, limitViolationWarning}, 24'h0);
        upperVoltageLimit = 16'hFFFF;
        for (int s = 0; s < 4; s++) begin
            loopScaleFactor = 2'(s);
            cmd(1, 8'h21, 16'(dacTab[s] / 8 + 2), 16'h0000);
            wait_ref(24'(dacTab[s]));
        end
        loopScaleFactor = 2'h0;
        upperVoltageLimit = 16'h0C00;
        cmd(1, 8'h21, 16'h0150, 16'h0000);
        pulse_clear();
        // Offset pushing the sum past the ceiling is refused
        cmd(1, 8'h22, 16'h0018, 16'h0000);
        tick(2);
        cmp_lvl({22'h0, invalidDataFlag, alertHost}, 24'h3);
        cmd(0, 8'h22, 16'h0000, 16'h0001);
        pulse_clear();
        lowerVoltageLimit = 16'h0A00;
        cmd(1, 8'h22, 16'hFFE0, 16'h0000);
        wait_ref(24'h000A00);
        cmp_lvl({23'h0, limitViolationWarning}, 24'h1);
        lowerVoltageLimit = 16'h0100;
        // Offset backup saturates at exponent -12
        cmd(1, 8'h21, 16'h0100, 16'h0000);
        cmd(1, 8'h22, 16'h0020, 16'h0000);
        tick(3);
        cmp_lvl({16'h0, nvmOffsetBackup}, 24'h00007F);
        cmd(1, 8'h22, 16'hFFFF, 16'h0000);
        tick(3);
        cmp_lvl({16'h0, nvmOffsetBackup}, 24'h0000F8);
        // Format rewrites at both exponent ends
        cmd(1, 8'h20, 16'h0014, 16'h0000);
        cmd(0, 8'h21, 16'h0000, 16'h0800);
        cmd(0, 8'h22, 16'h0000, 16'hFFF8);
        cmd(1, 8'h20, 16'h001C, 16'h0000);
        cmd(0, 8'h21, 16'h0000, 16'h0008);
        cmd(0, 8'h22, 16'h0000, 16'hFFFF);
        cmd(1, 8'h21, 16'h0009, 16'h0000);
        cmd(1, 8'h20, 16'h0017, 16'h0000);
        cmd(0, 8'h21, 16'h0000, 16'h0120);
        pulse_clear();
        cmd(1, 8'h20, 16'h0010, 16'h0000);
        tick(2);
        cmp_lvl({23'h0, invalidDataFlag}, 24'h1);
        cmd(0, 8'h20, 16'h0000, 16'h0017);
        cmd(1, 8'h99, 16'h0000, 16'h0000);
        // Reset pin, fault reload and strap source
        cmd(1, 8'h21, 16'h0050, 16'h0000);
        powerGoodResetPin_n = 1'b0;
        tick(5);
        powerGoodResetPin_n = 1'b1;
        tick(4);
        cmd(0, 8'h21, 16'h0000, 16'h0100);
        cmd(1, 8'h21, 16'h0050, 16'h0000);
        for (int r = 0; r < 2; r++) begin
            faultTargetReload = 1'(r);
            faultShutdown = 1'b1;
            tick(1);
            faultShutdown = 1'b0;
            tick(3);
            cmd(0, 8'h21, 16'h0000, (r == 1) ? 16'h0100 : 16'h0050);
        end
        strapSourceSelect = 1'b1;
        restoreDefaults = 1'b1;
        tick(1);
        restoreDefaults = 1'b0;
        tick(4);
        cmp_lvl({8'h00, bootVoltage}, 24'h000400);
        cmd(0, 8'h21, 16'h0000, 16'h0080);
        // Pin ignored outside its reset role; reload takes the strap seen at restore, not a later one
        pinIsReset = 1'b0;
        voltageStrapValue = 16'h0600;
        cmd(1, 8'h21, 16'h0050, 16'h0000);
        powerGoodResetPin_n = 1'b0;
        tick(5);
        powerGoodResetPin_n = 1'b1;
        cmd(0, 8'h21, 16'h0000, 16'h0050);
        faultShutdown = 1'b1;
        tick(1);
        faultShutdown = 1'b0;
        tick(3);
        cmd(0, 8'h21, 16'h0000, 16'h0080);
        tick(2);
        close_out();
    end
endmodule : tb_vtc_target
`default_nettype wire
